// ---- core/port_a_params.svh ----
// Constants of the port A register block: indices, resets, bus codes.
// Assumes inclusion by bare name from the core/ sources.
//
// Function
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only; reads return all ones.
// - Direction clears on reset and hardware standby, holds in software standby.
// - Output pins keep driving their state during software standby.
// - Data read gives latch for output pins, pin level for input pins.
// - Data register clears on reset and hardware standby, holds in software standby.
// - Enabled pattern bits ignore CPU writes; only a pattern transfer changes them.
// - Data register holds pattern-controller output for groups 0 and 1.
// - Free upper pin: dir 0 input, dir 1 port output, enabled pattern output.
// - Pin 7 is channel-2 compare B when its field selects compare output.
// - Pin 7 feeds channel-2 capture B when field bit2 set and not PWM.
// - Pin 6 is channel-2 compare A in PWM or compare; capture when bit2.
// - Pin 5 is channel-1 compare B when its field selects compare output.
// - Pin 5 feeds channel-1 capture B when field bit2 set and not PWM.
`ifndef PORT_A_PARAMS_SVH
`define PORT_A_PARAMS_SVH

// ************************************************
// Register map
// ************************************************
`define PA_ADDR_W 20
`define PA_DIR_IDX 16'hFFD1
`define PA_DATA_IDX 16'hFFD3
`define PA_DIR_RESET 8'h00
`define PA_DATA_RESET 8'h00
`define PA_DIR_READ 8'hFF

// ************************************************
// Bus response codes
// ************************************************
`define PA_RESP_OKAY 2'h0
`define PA_RESP_SLVERR 2'h2

`endif

// ---- core/port_a_pkg.sv ----
// Types shared by the port A sources.
// Assumes nothing beyond a SystemVerilog compiler.
package port_a_pkg;
	typedef enum logic [1:0] {
		FUNC_PORT_IN,
		FUNC_PORT_OUT,
		FUNC_PATTERN_OUT,
		FUNC_TIMER_OUT
	} pin_func_t;
endpackage

// ---- core/port_a_pin_cell.sv ----
// One port A pin: picks timer, pattern, port output or input.
// Assumes all inputs come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module port_a_pin_cell (
	// Settings
	input wire logic dir_bit,
	input wire logic nde_bit,
	input wire logic data_bit,
	input wire logic hw_standby,
	// Timer claim
	input wire logic timer_sel,
	input wire logic timer_out,
	// Pin drive
	output logic pin_out,
	output logic pin_oe,
	output port_a_pkg::pin_func_t func
);
	always_comb begin
		if (timer_sel) begin
			func = port_a_pkg::FUNC_TIMER_OUT;
		end else if (!dir_bit) begin
			func = port_a_pkg::FUNC_PORT_IN;
		end else if (nde_bit) begin
			func = port_a_pkg::FUNC_PATTERN_OUT;
		end else begin
			func = port_a_pkg::FUNC_PORT_OUT;
		end
	end

	always_comb begin
		pin_oe = !hw_standby && (func != port_a_pkg::FUNC_PORT_IN);
		pin_out = (func == port_a_pkg::FUNC_TIMER_OUT) ? timer_out : data_bit;
	end
endmodule
`default_nettype wire

// ---- core/port_a_gpio_pin_mux.sv ----
// Port A: eight-bit I/O port with AXI4-Lite registers and upper-pin muxing.
// Assumes timer and pattern controller signals on aclk; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "port_a_params.svh"
module port_a_gpio_pin_mux (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [`PA_ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// AXI4-Lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// AXI4-Lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read address
	input wire logic [`PA_ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Standby controls
	input wire logic hw_standby,
	input wire logic sw_standby,
	// Pattern controller
	input wire logic [7:0] next_data_enable_reg,
	input wire logic [7:0] next_data_reg,
	input wire logic next_data_transfer,
	// Timer settings
	input wire logic ch1_pwm_mode,
	input wire logic ch2_pwm_mode,
	input wire logic [2:0] ch1_io_control_b,
	input wire logic [2:0] ch2_io_control_a,
	input wire logic [2:0] ch2_io_control_b,
	// Timer compare outputs
	input wire logic ch1_compare_capture_b_out,
	input wire logic ch2_compare_capture_a_out,
	input wire logic ch2_compare_capture_b_out,
	// Timer capture inputs
	output logic ch1_compare_capture_b_in,
	output logic ch2_compare_capture_a_in,
	output logic ch2_compare_capture_b_in,
	// Pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe
);
	// ************************************************
	// Functions
	// ************************************************
	function automatic logic is_reg(input logic [`PA_ADDR_W-1:0] a, input logic [15:0] idx);
		is_reg = (a[`PA_ADDR_W-1:2] == {2'h0, idx});
	endfunction

	// Field selects compare output: bit2 clear, bits1:0 nonzero
	function automatic logic compare_out_sel(input logic [2:0] f);
		compare_out_sel = !f[2] && (f[1:0] != 2'h0);
	endfunction

	// ************************************************
	// State
	// ************************************************
	logic [7:0] dir_reg, dir_next;
	logic [7:0] data_reg, data_next;
	logic [7:0] pin_meta_reg, pin_sync_reg;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [`PA_ADDR_W-1:0] waddr_reg, waddr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic wstrb0_reg, wstrb0_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [2:0] cap_reg, cap_next;
	logic write_do;
	logic [7:0] timer_sel;
	logic [7:0] timer_out;
	port_a_pkg::pin_func_t func [8];

	// ************************************************
	// Pin synchroniser
	// ************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta_reg <= 8'h00;
			pin_sync_reg <= 8'h00;
		end else begin
			pin_meta_reg <= pin_in;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ************************************************
	// AXI4-Lite slave
	// ************************************************
	// One write in flight; address and data may arrive in either order
	assign awready = !aw_have_reg && !bvalid_reg;
	assign wready = !w_have_reg && !bvalid_reg;
	assign arready = !rvalid_reg;
	assign write_do = aw_have_reg && w_have_reg && !bvalid_reg;

	always_comb begin
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb0_next = wstrb0_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (awvalid && awready) begin
			aw_have_next = 1'b1;
			waddr_next = awaddr;
		end
		if (wvalid && wready) begin
			w_have_next = 1'b1;
			wdata_next = wdata[7:0];
			wstrb0_next = wstrb[0];
		end
		if (write_do) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			if (is_reg(waddr_reg, `PA_DIR_IDX) || is_reg(waddr_reg, `PA_DATA_IDX)) begin
				bresp_next = `PA_RESP_OKAY;
			end else begin
				bresp_next = `PA_RESP_SLVERR;
			end
		end else if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
	end

	always_comb begin
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (arvalid && arready) begin
			rvalid_next = 1'b1;
			rresp_next = `PA_RESP_OKAY;
			if (is_reg(araddr, `PA_DIR_IDX)) begin
				rdata_next = `PA_DIR_READ;
			end else if (is_reg(araddr, `PA_DATA_IDX)) begin
				// Latch or pin level per bit
				rdata_next = (data_reg & dir_reg) | (pin_sync_reg & ~dir_reg);
			end else begin
				rdata_next = 8'h00;
				rresp_next = `PA_RESP_SLVERR;
			end
		end else if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= '0;
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `PA_RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= `PA_RESP_OKAY;
			rdata_reg <= 8'h00;
		end else begin
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb0_reg <= wstrb0_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign rvalid = rvalid_reg;
	assign rresp = rresp_reg;
	assign rdata = {24'h000000, rdata_reg};

	// ************************************************
	// Port registers
	// ************************************************
	always_comb begin
		dir_next = dir_reg;
		data_next = data_reg;
		if (!sw_standby) begin
			if (write_do && wstrb0_reg && is_reg(waddr_reg, `PA_DIR_IDX)) begin
				dir_next = wdata_reg;
			end
			for (int i = 0; i < 8; i++) begin
				if (next_data_enable_reg[i]) begin
					if (next_data_transfer) begin
						// Pattern data held in port latch
						data_next[i] = next_data_reg[i];
					end
				end else if (write_do && wstrb0_reg && is_reg(waddr_reg, `PA_DATA_IDX)) begin
					data_next[i] = wdata_reg[i];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		// Clear on reset and hardware standby
		if (!aresetn || hw_standby) begin
			dir_reg <= `PA_DIR_RESET;
			data_reg <= `PA_DATA_RESET;
		end else begin
			dir_reg <= dir_next;
			data_reg <= data_next;
		end
	end

	// ************************************************
	// Upper pin timer sharing
	// ************************************************
	always_comb begin
		timer_sel = 8'h00;
		timer_out = 8'h00;
		timer_sel[7] = compare_out_sel(ch2_io_control_b);
		timer_out[7] = ch2_compare_capture_b_out;
		timer_sel[6] = ch2_pwm_mode || compare_out_sel(ch2_io_control_a);
		timer_out[6] = ch2_compare_capture_a_out;
		timer_sel[5] = compare_out_sel(ch1_io_control_b);
		timer_out[5] = ch1_compare_capture_b_out;
	end

	// Capture paths run beside port use; registered for clean timer input
	always_comb begin
		cap_next[2] = ch2_io_control_b[2] && !ch2_pwm_mode && pin_sync_reg[7];
		cap_next[1] = ch2_io_control_a[2] && pin_sync_reg[6];
		cap_next[0] = ch1_io_control_b[2] && !ch1_pwm_mode && pin_sync_reg[5];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cap_reg <= 3'h0;
		end else begin
			cap_reg <= cap_next;
		end
	end

	assign ch2_compare_capture_b_in = cap_reg[2];
	assign ch2_compare_capture_a_in = cap_reg[1];
	assign ch1_compare_capture_b_in = cap_reg[0];

	// ************************************************
	// Pin cells
	// ************************************************
	// Drive kept through software standby
	for (genvar g = 0; g < 8; g++) begin : g_pin
		port_a_pin_cell u_cell (
			.dir_bit(dir_reg[g]),
			.nde_bit(next_data_enable_reg[g]),
			.data_bit(data_reg[g]),
			.hw_standby(hw_standby),
			.timer_sel(timer_sel[g]),
			.timer_out(timer_out[g]),
			.pin_out(pin_out[g]),
			.pin_oe(pin_oe[g]),
			.func(func[g])
		);
	end

	// ************************************************
	// Assertions
	// ************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_dir_readback: assert property (
		(arvalid && arready && is_reg(araddr, `PA_DIR_IDX)) |=> (rvalid && rdata[7:0] == 8'hFF))
		else $error("direction read did not return all ones");
	chk_read_mix: assert property (
		(arvalid && arready && is_reg(araddr, `PA_DATA_IDX)) |=>
		(rdata[7:0] == (($past(data_reg) & $past(dir_reg)) | ($past(pin_sync_reg) & ~$past(dir_reg)))))
		else $error("data read mixed wrong sources");
	chk_low_dir: assert property (
		!hw_standby |-> (pin_oe[4:0] == dir_reg[4:0]))
		else $error("low pin drive differs from direction");
	chk_hw_clear: assert property (
		hw_standby |=> (dir_reg == 8'h00 && data_reg == 8'h00
		&& (pin_oe & ~timer_sel) == 8'h00))
		else $error("hardware standby did not clear port");
	chk_sw_hold: assert property (
		(sw_standby && !hw_standby) |=> ($stable(dir_reg) && $stable(data_reg)))
		else $error("software standby changed registers");
	chk_sw_drive: assert property (
		(sw_standby && !hw_standby) ##1 (sw_standby && !hw_standby) |-> $stable(pin_oe[4:0]))
		else $error("software standby dropped output drive");
	chk_nde_block: assert property (
		(!sw_standby && !hw_standby && !next_data_transfer) |=>
		((data_reg & $past(next_data_enable_reg)) == ($past(data_reg) & $past(next_data_enable_reg))))
		else $error("enabled bit changed without transfer");
	chk_transfer_load: assert property (
		(next_data_transfer && !sw_standby && !hw_standby) |=>
		((data_reg & $past(next_data_enable_reg)) == ($past(next_data_reg) & $past(next_data_enable_reg))))
		else $error("transfer did not load data bits");
	chk_pattern_sel: assert property (
		(!timer_sel[7] && dir_reg[7] && next_data_enable_reg[7])
		|-> (func[7] == port_a_pkg::FUNC_PATTERN_OUT && pin_out[7] == data_reg[7]))
		else $error("pin 7 pattern output not selected");
	chk_pin7_timer: assert property (
		(!ch2_io_control_b[2] && ch2_io_control_b[1:0] != 2'h0 && !hw_standby)
		|-> (pin_oe[7] && pin_out[7] == ch2_compare_capture_b_out))
		else $error("pin 7 not compare output");
	chk_pin7_capture: assert property (
		(ch2_io_control_b[2] && !ch2_pwm_mode) ##1 (ch2_io_control_b[2] && !ch2_pwm_mode)
		|=> (ch2_compare_capture_b_in == $past(pin_sync_reg[7], 1)))
		else $error("pin 7 capture path wrong");
	chk_pin6_timer: assert property (
		(ch2_pwm_mode && !hw_standby) |-> (pin_oe[6] && pin_out[6] == ch2_compare_capture_a_out))
		else $error("pin 6 not compare output in PWM");
	chk_pin5_timer: assert property (
		(!ch1_io_control_b[2] && ch1_io_control_b[1:0] != 2'h0 && !hw_standby)
		|-> (pin_oe[5] && pin_out[5] == ch1_compare_capture_b_out))
		else $error("pin 5 not compare output");
	chk_pin5_capture: assert property (
		ch1_pwm_mode |=> !ch1_compare_capture_b_in)
		else $error("pin 5 captured during PWM");
	chk_write_pin: assert property (
		(write_do && wstrb0_reg && is_reg(waddr_reg, `PA_DATA_IDX) && !next_data_enable_reg[0]
		&& !sw_standby && !hw_standby) ##1 (dir_reg[0] && !hw_standby)
		|-> (pin_oe[0] && pin_out[0] == $past(wdata_reg[0])))
		else $error("written data not on pin");

	cov_dir_write: cover property (write_do && is_reg(waddr_reg, `PA_DIR_IDX));
	cov_data_read: cover property (arvalid && arready && is_reg(araddr, `PA_DATA_IDX));
	cov_transfer: cover property (next_data_transfer && next_data_enable_reg != 8'h00);
	cov_timer_pin: cover property (timer_sel[7] && dir_reg[7]);
endmodule
`default_nettype wire

// ---- tb/pin_partner.sv ----
// Board-side circuitry on the port A pins.
// Assumes pin_oe high means the port drives the pad.
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
	// Port side
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Board side
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	// Port wins where it drives, board elsewhere
	assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the port A block over AXI4-Lite.
// Assumes the design package and parameter header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "port_a_params.svh"
module tb_top;
	localparam logic [19:0] A_DIR = {2'h0, `PA_DIR_IDX, 2'h0};
	localparam logic [19:0] A_DAT = {2'h0, `PA_DATA_IDX, 2'h0};
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, hw_standby, sw_standby, xfer, c1_pwm, c2_pwm;
	logic [19:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] nde, ndr, ext, pin_in, pin_out, pin_oe, dir_m, dat_m;
	logic [2:0] c1_b, c2_a, c2_b, cmp, cap;
	int num_errors, samples_checked;

	port_a_gpio_pin_mux dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .hw_standby(hw_standby),
		.sw_standby(sw_standby), .next_data_enable_reg(nde), .next_data_reg(ndr),
		.next_data_transfer(xfer), .ch1_pwm_mode(c1_pwm), .ch2_pwm_mode(c2_pwm),
		.ch1_io_control_b(c1_b), .ch2_io_control_a(c2_a), .ch2_io_control_b(c2_b),
		.ch1_compare_capture_b_out(cmp[0]), .ch2_compare_capture_a_out(cmp[1]),
		.ch2_compare_capture_b_out(cmp[2]), .ch1_compare_capture_b_in(cap[0]),
		.ch2_compare_capture_a_in(cap[1]), .ch2_compare_capture_b_in(cap[2]),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));

	pin_partner board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [31:0] exp_rd(input logic [7:0] d, input logic [7:0] v,
		input logic [7:0] e);
		return {24'h0, (v & d) | (e & ~d)};
	endfunction

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Both channels offered together, each dropped at its own handshake
	task automatic wr(input logic [19:0] a, input logic [7:0] d, output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Raised after the take, so back-to-back calls never drive it twice in one step
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdr(input logic [19:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// ************************************************
	// Clock, reset values, watchdog
	// ************************************************
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, sw_standby} = '0;
		{xfer, c1_pwm, c2_pwm, c1_b, c2_a, c2_b, cmp} = '0;
		{awaddr, araddr, wdata, nde, ndr} = '0;
		ext = 8'h5A;
		num_errors = 0;
		samples_checked = 0;
	end

	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		summarize();
	end

	// ************************************************
	// Scenarios
	// ************************************************
	initial begin
		void'($urandom(32'h5574));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("oe_reset", 32'(pin_oe), 32'h0);
		rdr(A_DIR, rd, rsp);
		chk("dir_read", rd, 32'h000000FF);
		rdr(A_DAT, rd, rsp);
		chk("data_reset", rd, exp_rd(8'h00, 8'h00, ext));
		// Random direction, data and board levels, all-out and all-in first
		for (int i = 0; i < 12; i++) begin
			dir_m = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			dat_m = 8'($urandom);
			ext <= 8'($urandom);
			wr(A_DIR, dir_m, rsp);
			wr(A_DAT, dat_m, rsp);
			chk("wr_resp", 32'(rsp), 32'(`PA_RESP_OKAY));
			repeat (3) @(posedge aclk);
			chk("oe", 32'(pin_oe), 32'(dir_m));
			chk("out", 32'(pin_out & dir_m), 32'(dat_m & dir_m));
			rdr(A_DAT, rd, rsp);
			chk("data_read", rd, exp_rd(dir_m, dat_m, ext));
			chk("rd_resp", 32'(rsp), 32'(`PA_RESP_OKAY));
			rdr(A_DIR, rd, rsp);
			chk("dir_read", rd, 32'h000000FF);
		end
		rdr(20'h00010, rd, rsp);
		chk("unmapped_rresp", 32'(rsp), 32'(`PA_RESP_SLVERR));
		wr(A_DIR, 8'hF0, rsp);
		wr(A_DAT, 8'hA5, rsp);
		// Software standby freezes both registers, outputs keep driving
		sw_standby <= 1'b1;
		wr(A_DAT, 8'h5A, rsp);
		wr(A_DIR, 8'h00, rsp);
		chk("sw_oe", 32'(pin_oe), 32'h000000F0);
		chk("sw_out", 32'(pin_out & 8'hF0), 32'h000000A0);
		rdr(A_DAT, rd, rsp);
		chk("sw_data", rd, exp_rd(8'hF0, 8'hA5, ext));
		sw_standby <= 1'b0;
		hw_standby <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("hw_oe", 32'(pin_oe), 32'h0);
		hw_standby <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("hw_dir", 32'(pin_oe), 32'h0);
		wr(A_DIR, 8'hFF, rsp);
		rdr(A_DAT, rd, rsp);
		chk("hw_data", rd, 32'h0);
		// Pattern bits ignore the CPU, take the transfer
		nde <= 8'hE0;
		ndr <= 8'hC0;
		wr(A_DAT, 8'hFF, rsp);
		rdr(A_DAT, rd, rsp);
		chk("nde_block", rd, 32'h0000001F);
		xfer <= 1'b1;
		@(posedge aclk);
		xfer <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("tp_out", 32'(pin_out), 32'h000000DF);
		rdr(A_DAT, rd, rsp);
		chk("tp_data", rd, 32'h000000DF);
		nde <= 8'h00;
		wr(A_DIR, 8'h00, rsp);
		// Every timer field code on the three shared pins
		for (int m = 0; m < 8; m++) begin
			c1_b <= 3'(m);
			c2_a <= 3'(m);
			c2_b <= 3'(m);
			cmp <= 3'($urandom);
			ext <= 8'($urandom);
			repeat (5) @(posedge aclk);
			if (m < 4 && m > 0) begin
				chk("tmr_oe", 32'(pin_oe[7:5]), 32'h7);
				chk("tmr_out", 32'(pin_out[7:5]), 32'(cmp));
			end else begin
				chk("free_oe", 32'(pin_oe[7:5]), 32'h0);
			end
			if (m > 3) begin
				chk("capture", 32'(cap), 32'(ext[7:5]));
			end
		end
		// Both PWM modes on, capture fields set on the B pins, board high
		c1_b <= 3'h4;
		c2_a <= 3'h0;
		c2_b <= 3'h4;
		c1_pwm <= 1'b1;
		c2_pwm <= 1'b1;
		cmp <= 3'h2;
		ext <= 8'hFF;
		repeat (4) @(posedge aclk);
		chk("pwm_oe", 32'(pin_oe[6]), 32'h1);
		chk("pwm_out", 32'(pin_out[6]), 32'h1);
		chk("pwm_cap", 32'(cap), 32'h0);
		chk("pwm_free", 32'({pin_oe[7], pin_oe[5]}), 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
